// ### rtl/stm_regs.vh
// register map, field positions, reset values and bus codes of the supply and temperature monitor
//
// Summary of operation
// RQ1 - over-temperature change flag sets whenever the over-temperature status toggles
// RQ2 - both change flags clear only by writing one; writing zero keeps them
// RQ3 - over-temperature irq request while its change flag and enable bit are set
// RQ4 - entering reduced power mode never clears either change flag
// RQ5 - over-temperature status is read-only, one only above threshold in full performance
// RQ6 - low-supply status is read-only, one only below level in full performance
// RQ7 - low-supply change flag sets each time the low-supply status changes
// RQ8 - low-supply irq request while its change flag and enable bit are set
// RQ9 - temperature control bit 3 enables the temperature sensing function
// RQ10 - temperature control bit 4 routes internal voltage to the converter channel
// RQ11 - bit 5 picks temperature voltage or bandgap, only while routing enabled
// RQ12 - temperature control bits 7 and 6 writable only in test mode
// RQ13 - reduced power mode disables supply detect, supply reset and temperature detect
// RQ14 - comparator outputs are synchronised before change detection, one flag per edge
`ifndef STM_REGS_VH
`define STM_REGS_VH

// register indices; byte address is four times the index
`define STM_IDX_TEMP_CTRL    10'h2F0
`define STM_IDX_SUPPLY_CTRL  10'h2F1
`define STM_IDX_WAKE_CTRL    10'h2F2
`define STM_IDX_WAKE_TRIM    10'h2F3
`define STM_IDX_WAKE_RATE_H  10'h2F4
`define STM_IDX_WAKE_RATE_L  10'h2F5
`define STM_IDX_RESERVED     10'h2F6
`define STM_IDX_TEMP_TRIM    10'h2F7
`define STM_IDX_IRQ_STATUS   10'h2F8
`define STM_IDX_IRQ_CLEAR    10'h2F9
`define STM_IDX_IRQ_ENABLE   10'h2FA

// shared field positions
`define STM_BIT_FLAG         0
`define STM_BIT_IRQ_EN       1
`define STM_BIT_STATUS       2
// temperature control
`define STM_BIT_SENSE_EN     3
`define STM_BIT_ROUTE_EN     4
`define STM_BIT_VOLT_SEL     5
`define STM_BIT_TEST_LO      6
`define STM_BIT_TEST_HI      7
// periodic wake control
`define STM_BIT_WAKE_EN      2
`define STM_BIT_WAKE_CLK     7
`define STM_MASK_WAKE_CTRL   8'h1E
// temperature and wake trim
`define STM_BIT_TRIM_OE      7
`define STM_MASK_TEMP_TRIM   8'h8F
`define STM_MASK_WAKE_TRIM   8'hFC
// interrupt status layout
`define STM_IRQ_TEMP         0
`define STM_IRQ_SUPPLY       1

// reset values
`define STM_RST_TEMP_CTRL    8'h10
`define STM_RST_ZERO8        8'h00

// bus answers
`define STM_RESP_OKAY        2'h0
`define STM_RESP_SLVERR      2'h2

`endif

// ### rtl/stm_sync.v
// two-stage synchroniser for asynchronous comparator levels
`timescale 1ns/100ps
module stm_sync #(
    parameter WIDTH = 2
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rst_n,
    // levels
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] sync_q;

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
        always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= asyncIn[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end
endgenerate

assign syncOut = sync_q;

endmodule // stm_sync

// ### rtl/stm_flag.v
// sticky event flags with write-one-to-clear, set wins over clear
`timescale 1ns/100ps
module stm_flag #(
    parameter WIDTH = 2
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rst_n,
    // events and clears
    input  wire [WIDTH-1:0] setIn,
    input  wire [WIDTH-1:0] clrIn,
    output wire [WIDTH-1:0] flagOut
);

reg [WIDTH-1:0] flag_q;

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gFlag
        always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                flag_q[i] <= 1'b0;
            end else if (setIn[i]) begin
                flag_q[i] <= 1'b1;
            end else if (clrIn[i]) begin
                flag_q[i] <= 1'b0;
            end
        end
    end
endgenerate

assign flagOut = flag_q;

endmodule // stm_flag

// ### rtl/stm_monitor.v
// supply and temperature monitor register bank with AXI4-Lite slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "stm_regs.vh"
module stm_monitor (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // write address channel
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // write data channel
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // write response channel
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // read address channel
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // read data channel
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // analog comparators, asynchronous
    input  wire        overTempCmp,
    input  wire        lowSupplyCmp,
    // power mode and test mode, same clock
    input  wire        reducedPowerMode,
    input  wire        shutdownMode,
    input  wire        testModeEn,
    // analog controls
    output wire        tempSenseEnable,
    output wire        adcInternalRoute,
    output wire        adcSelectBandgap,
    output wire        adcSelectTemp,
    output wire [1:0]  tempTestBits,
    output wire        monitorsActive,
    output wire        tempTrimOutputEnable,
    output wire [3:0]  tempTrimValue,
    // periodic wake settings
    output wire [7:0]  wakeControl,
    output wire [5:0]  wakePeriodTrim,
    output wire [15:0] wakeRateValue,
    // interrupt requests
    output wire        overTempIrq,
    output wire        lowSupplyIrq,
    output wire        irqOut
);

////////////////////////////////////////////////////////////////////////////////
// bus slave state

reg        awready_q;
reg        wready_q;
reg        awHeld_q;
reg        wHeld_q;
reg [9:0]  awIdx_q;
reg [7:0]  wByte_q;
reg        wLane_q;
reg        bvalid_q;
reg [1:0]  bresp_q;
reg        arready_q;
reg        rvalid_q;
reg [31:0] rdata_q;
reg [1:0]  rresp_q;

wire awHit = s_axi_awvalid & awready_q;
wire wHit  = s_axi_wvalid & wready_q;
wire arHit = s_axi_arvalid & arready_q;
wire doWrite = awHeld_q & wHeld_q & ~bvalid_q;
wire wrEn = doWrite & wLane_q;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        awready_q <= 1'b0;
        awHeld_q  <= 1'b0;
        awIdx_q   <= 10'h000;
    end else if (awHit) begin
        awready_q <= 1'b0;
        awHeld_q  <= 1'b1;
        awIdx_q   <= s_axi_awaddr[11:2];
    end else if (doWrite) begin
        awHeld_q  <= 1'b0;
    end else if (!awHeld_q && !bvalid_q) begin
        awready_q <= 1'b1;
    end
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        wready_q <= 1'b0;
        wHeld_q  <= 1'b0;
        wByte_q  <= 8'h00;
        wLane_q  <= 1'b0;
    end else if (wHit) begin
        wready_q <= 1'b0;
        wHeld_q  <= 1'b1;
        wByte_q  <= s_axi_wdata[7:0];
        wLane_q  <= s_axi_wstrb[0];
    end else if (doWrite) begin
        wHeld_q  <= 1'b0;
    end else if (!wHeld_q && !bvalid_q) begin
        wready_q <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// address decode

reg wrMapped;
always @* begin
    case (awIdx_q)
        `STM_IDX_TEMP_CTRL,
        `STM_IDX_SUPPLY_CTRL,
        `STM_IDX_WAKE_CTRL,
        `STM_IDX_WAKE_TRIM,
        `STM_IDX_WAKE_RATE_H,
        `STM_IDX_WAKE_RATE_L,
        `STM_IDX_RESERVED,
        `STM_IDX_TEMP_TRIM,
        `STM_IDX_IRQ_STATUS,
        `STM_IDX_IRQ_CLEAR,
        `STM_IDX_IRQ_ENABLE: wrMapped = 1'b1;
        default:             wrMapped = 1'b0;
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        bvalid_q <= 1'b0;
        bresp_q  <= `STM_RESP_OKAY;
    end else if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wrMapped ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
    end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
    end
end

wire wrTemp   = wrEn & (awIdx_q == `STM_IDX_TEMP_CTRL);
wire wrSupply = wrEn & (awIdx_q == `STM_IDX_SUPPLY_CTRL);
wire wrWCtrl  = wrEn & (awIdx_q == `STM_IDX_WAKE_CTRL);
wire wrWTrim  = wrEn & (awIdx_q == `STM_IDX_WAKE_TRIM);
wire wrRateH  = wrEn & (awIdx_q == `STM_IDX_WAKE_RATE_H);
wire wrRateL  = wrEn & (awIdx_q == `STM_IDX_WAKE_RATE_L);
wire wrTTrim  = wrEn & (awIdx_q == `STM_IDX_TEMP_TRIM);
wire wrIrqClr = wrEn & (awIdx_q == `STM_IDX_IRQ_CLEAR);
wire wrIrqEn  = wrEn & (awIdx_q == `STM_IDX_IRQ_ENABLE);

////////////////////////////////////////////////////////////////////////////////
// control registers

reg [7:0]  tempCtrl_q;
reg [1:0]  supplyCtrl_q;
reg [7:0]  wakeCtrl_q;
reg [5:0]  wakeTrim_q;
reg [15:0] wakeRate_q;
reg [7:0]  tempTrim_q;
reg [1:0]  irqEnable_q;

wire wakeRunning = wakeCtrl_q[`STM_BIT_WAKE_EN];

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        tempCtrl_q <= `STM_RST_TEMP_CTRL;
    end else if (wrTemp) begin
        // RQ9 sense enable
        tempCtrl_q[`STM_BIT_SENSE_EN] <= wByte_q[`STM_BIT_SENSE_EN];
        // RQ10 route enable
        tempCtrl_q[`STM_BIT_ROUTE_EN] <= wByte_q[`STM_BIT_ROUTE_EN];
        // RQ11 voltage select
        tempCtrl_q[`STM_BIT_VOLT_SEL] <= wByte_q[`STM_BIT_VOLT_SEL];
        tempCtrl_q[`STM_BIT_IRQ_EN]   <= wByte_q[`STM_BIT_IRQ_EN];
        // RQ12 test-mode-only bits
        if (testModeEn) begin
            tempCtrl_q[`STM_BIT_TEST_HI] <= wByte_q[`STM_BIT_TEST_HI];
            tempCtrl_q[`STM_BIT_TEST_LO] <= wByte_q[`STM_BIT_TEST_LO];
        end
    end
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        supplyCtrl_q <= 2'h0;
    end else if (wrSupply) begin
        supplyCtrl_q[`STM_BIT_IRQ_EN] <= wByte_q[`STM_BIT_IRQ_EN];
    end
end

// clock select and rate lock while the wake timer runs
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        wakeCtrl_q <= `STM_RST_ZERO8;
        wakeRate_q <= 16'h0000;
    end else begin
        if (wrWCtrl) begin
            wakeCtrl_q[4:1] <= wByte_q[4:1];
            if (!wakeRunning) begin
                wakeCtrl_q[`STM_BIT_WAKE_CLK] <= wByte_q[`STM_BIT_WAKE_CLK];
            end
        end
        if (wrRateH && !wakeRunning) begin
            wakeRate_q[15:8] <= wByte_q;
        end
        if (wrRateL && !wakeRunning) begin
            wakeRate_q[7:0] <= wByte_q;
        end
    end
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        wakeTrim_q  <= 6'h00;
        tempTrim_q  <= `STM_RST_ZERO8;
        irqEnable_q <= 2'h0;
    end else begin
        if (wrWTrim) begin
            wakeTrim_q <= wByte_q[7:2];
        end
        if (wrTTrim) begin
            tempTrim_q <= wByte_q & `STM_MASK_TEMP_TRIM;
        end
        if (wrIrqEn) begin
            irqEnable_q <= wByte_q[1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// monitor status and change flags

wire [1:0] cmpSync;
reg        overTemp_q;
reg        lowSupply_q;

// RQ14 comparator synchronisation
stm_sync #(
    .WIDTH   (2)
) uSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn ({lowSupplyCmp, overTempCmp}),
    .syncOut (cmpSync)
);

// RQ13 detect only in full performance
wire fullPerf = ~reducedPowerMode & ~shutdownMode;

// RQ5 gated temperature status
wire overTempD = cmpSync[0] & fullPerf & tempCtrl_q[`STM_BIT_SENSE_EN];
// RQ6 gated supply status
wire lowSupplyD = cmpSync[1] & fullPerf;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        overTemp_q  <= 1'b0;
        lowSupply_q <= 1'b0;
    end else begin
        overTemp_q  <= overTempD;
        lowSupply_q <= lowSupplyD;
    end
end

// RQ1 temperature toggle event
wire tempEvent = overTempD ^ overTemp_q;
// RQ7 supply change event
wire supplyEvent = lowSupplyD ^ lowSupply_q;

// RQ2 write-one clears only
wire [1:0] flagClr = {wrSupply & wByte_q[`STM_BIT_FLAG],
                      wrTemp & wByte_q[`STM_BIT_FLAG]};
wire [1:0] changeFlags;

// RQ4 flags hold across power modes
stm_flag #(
    .WIDTH   (2)
) uChange (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .setIn   ({supplyEvent, tempEvent}),
    .clrIn   (flagClr),
    .flagOut (changeFlags)
);

wire [1:0] irqStatus;

stm_flag #(
    .WIDTH   (2)
) uIrqStat (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .setIn   ({supplyEvent, tempEvent}),
    .clrIn   ({2{wrIrqClr}} & wByte_q[1:0]),
    .flagOut (irqStatus)
);

////////////////////////////////////////////////////////////////////////////////
// registered outputs

reg        overTempIrq_q;
reg        lowSupplyIrq_q;
reg        irqOut_q;
reg        adcSelBg_q;
reg        adcSelTemp_q;
reg        monitorsActive_q;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        overTempIrq_q    <= 1'b0;
        lowSupplyIrq_q   <= 1'b0;
        irqOut_q         <= 1'b0;
        adcSelBg_q       <= 1'b0;
        adcSelTemp_q     <= 1'b0;
        monitorsActive_q <= 1'b0;
    end else begin
        // RQ3 temperature request
        overTempIrq_q  <= changeFlags[0] & tempCtrl_q[`STM_BIT_IRQ_EN];
        // RQ8 supply request
        lowSupplyIrq_q <= changeFlags[1] & supplyCtrl_q[`STM_BIT_IRQ_EN];
        irqOut_q       <= |(irqStatus & irqEnable_q);
        // RQ11 select gated by routing
        adcSelBg_q     <= tempCtrl_q[`STM_BIT_ROUTE_EN] & tempCtrl_q[`STM_BIT_VOLT_SEL];
        adcSelTemp_q   <= tempCtrl_q[`STM_BIT_ROUTE_EN] & ~tempCtrl_q[`STM_BIT_VOLT_SEL];
        // RQ13 detectors off outside full performance
        monitorsActive_q <= fullPerf;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path

reg [7:0] rdByte;
reg       rdMapped;
always @* begin
    rdByte   = 8'h00;
    rdMapped = 1'b1;
    case (s_axi_araddr[11:2])
        `STM_IDX_TEMP_CTRL:   rdByte = {2'h0, tempCtrl_q[5:3], overTemp_q,
                                        tempCtrl_q[`STM_BIT_IRQ_EN], changeFlags[0]};
        `STM_IDX_SUPPLY_CTRL: rdByte = {5'h00, lowSupply_q,
                                        supplyCtrl_q[`STM_BIT_IRQ_EN], changeFlags[1]};
        `STM_IDX_WAKE_CTRL:   rdByte = wakeCtrl_q;
        `STM_IDX_WAKE_TRIM:   rdByte = {wakeTrim_q, 2'h0};
        `STM_IDX_WAKE_RATE_H: rdByte = wakeRate_q[15:8];
        `STM_IDX_WAKE_RATE_L: rdByte = wakeRate_q[7:0];
        `STM_IDX_RESERVED:    rdByte = 8'h00;
        `STM_IDX_TEMP_TRIM:   rdByte = tempTrim_q;
        `STM_IDX_IRQ_STATUS:  rdByte = {6'h00, irqStatus};
        `STM_IDX_IRQ_CLEAR:   rdByte = 8'h00;
        `STM_IDX_IRQ_ENABLE:  rdByte = {6'h00, irqEnable_q};
        default:              rdMapped = 1'b0;
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b0;
        rdata_q   <= 32'h00000000;
        rresp_q   <= `STM_RESP_OKAY;
    end else if (arHit) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h000000, rdByte};
        rresp_q   <= rdMapped ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
    end else if (rvalid_q) begin
        if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end else begin
        arready_q <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// port drive

assign s_axi_awready        = awready_q;
assign s_axi_wready         = wready_q;
assign s_axi_bvalid         = bvalid_q;
assign s_axi_bresp          = bresp_q;
assign s_axi_arready        = arready_q;
assign s_axi_rvalid         = rvalid_q;
assign s_axi_rdata          = rdata_q;
assign s_axi_rresp          = rresp_q;
assign tempSenseEnable      = tempCtrl_q[`STM_BIT_SENSE_EN];
assign adcInternalRoute     = tempCtrl_q[`STM_BIT_ROUTE_EN];
assign adcSelectBandgap     = adcSelBg_q;
assign adcSelectTemp        = adcSelTemp_q;
assign tempTestBits         = tempCtrl_q[7:6];
assign monitorsActive       = monitorsActive_q;
assign tempTrimOutputEnable = tempTrim_q[`STM_BIT_TRIM_OE];
assign tempTrimValue        = tempTrim_q[3:0];
assign wakeControl          = wakeCtrl_q;
assign wakePeriodTrim       = wakeTrim_q;
assign wakeRateValue        = wakeRate_q;
assign overTempIrq          = overTempIrq_q;
assign lowSupplyIrq         = lowSupplyIrq_q;
assign irqOut               = irqOut_q;

endmodule // stm_monitor

// ### testbench/stm_monitor_props.sv
// concurrent checks on the monitor register bank ports
`timescale 1ns/100ps
module stm_monitor_props (
    // clock and reset
    input wire        sys_clk,
    input wire        rst_n,
    // bus answers
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // modes
    input wire        reducedPowerMode,
    input wire        shutdownMode,
    input wire        testModeEn,
    // analog controls and requests
    input wire        adcInternalRoute,
    input wire        adcSelectBandgap,
    input wire        adcSelectTemp,
    input wire [1:0]  tempTestBits,
    input wire        monitorsActive,
    input wire        overTempIrq,
    input wire        lowSupplyIrq,
    input wire        irqOut
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////
    sequence s_write_window;
        s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
    endsequence
    property p_temp_irq_hold;
        $fell(overTempIrq) |-> s_write_window;
    endproperty
    a_temp_irq_hold: assert property (p_temp_irq_hold) else $error("temp request dropped unasked");
    property p_supply_irq_hold;
        $fell(lowSupplyIrq) |-> s_write_window;
    endproperty
    a_supply_irq_hold: assert property (p_supply_irq_hold) else $error("supply request dropped unasked");
    property p_irq_out_hold;
        $fell(irqOut) |-> s_write_window;
    endproperty
    a_irq_out_hold: assert property (p_irq_out_hold) else $error("irq output dropped unasked");
    property p_mode_gate;
        (reducedPowerMode || shutdownMode) |=> !monitorsActive;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("monitors active in low power");
    property p_route_off;
        !adcInternalRoute |=> !adcSelectBandgap && !adcSelectTemp;
    endproperty
    a_route_off: assert property (p_route_off) else $error("voltage routed while disabled");
    property p_sel_exclusive;
        !(adcSelectBandgap && adcSelectTemp);
    endproperty
    a_sel_exclusive: assert property (p_sel_exclusive) else $error("both voltages selected");
    property p_test_bits;
        !testModeEn [*2] |=> $stable(tempTestBits);
    endproperty
    a_test_bits: assert property (p_test_bits) else $error("test bits changed outside test");
    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write answer not held");
    property p_rdata_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read answer not held");
    c_temp_irq: cover property ($rose(overTempIrq));
    c_supply_irq: cover property ($rose(lowSupplyIrq));
    c_low_power: cover property (reducedPowerMode ##1 !monitorsActive);
endmodule // stm_monitor_props

bind stm_monitor stm_monitor_props u_props (
    .sys_clk, .rst_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .reducedPowerMode, .shutdownMode, .testModeEn, .adcInternalRoute,
    .adcSelectBandgap, .adcSelectTemp, .tempTestBits, .monitorsActive, .overTempIrq, .lowSupplyIrq, .irqOut
);

// ### testbench/stm_monitor_bench.sv
// self-checking bench for the monitor register bank
`timescale 1ns/100ps
`include "stm_regs.vh"
module stm_monitor_bench;
    localparam [9:0] TEMP = `STM_IDX_TEMP_CTRL, SUP = `STM_IDX_SUPPLY_CTRL, WAKE = `STM_IDX_WAKE_CTRL;
    localparam [9:0] WTRIM = `STM_IDX_WAKE_TRIM, RATEL = `STM_IDX_WAKE_RATE_L, RSVD = `STM_IDX_RESERVED;
    localparam [9:0] TTRIM = `STM_IDX_TEMP_TRIM, IST = `STM_IDX_IRQ_STATUS, ICLR = `STM_IDX_IRQ_CLEAR;
    localparam [9:0] IEN = `STM_IDX_IRQ_ENABLE;
    localparam [1:0] OK = `STM_RESP_OKAY, ERR = `STM_RESP_SLVERR, ANY = 2'h1;
    // stimulus
    logic        sys_clk, rst_n, overTempCmp, lowSupplyCmp, reducedPowerMode, shutdownMode, testModeEn;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    // observed
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp, tempTestBits;
    wire [31:0]  s_axi_rdata;
    wire         tempSenseEnable, adcInternalRoute, adcSelectBandgap, adcSelectTemp, monitorsActive;
    wire         tempTrimOutputEnable, overTempIrq, lowSupplyIrq, irqOut;
    wire [3:0]   tempTrimValue;
    wire [15:0]  wakeRateValue;
    integer      badCount, testsRun, i, m;
    logic [7:0]  v, wakeControl, tbl [5] = '{8'h38, 8'h18, 8'h28, 8'h00, 8'h08};

    stm_monitor u_dut (
        .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .overTempCmp, .lowSupplyCmp, .reducedPowerMode, .shutdownMode, .testModeEn, .tempSenseEnable,
        .adcInternalRoute, .adcSelectBandgap, .adcSelectTemp, .tempTestBits, .monitorsActive,
        .tempTrimOutputEnable, .tempTrimValue, .wakeControl, .wakePeriodTrim(), .wakeRateValue,
        .overTempIrq, .lowSupplyIrq, .irqOut
    );

    always #10 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (badCount == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        testsRun = testsRun + 1;
        if (g !== e) begin
            badCount = badCount + 1;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_up;
        badCount = badCount + 1;
        $display("unexpected bus answer expected handshake seen none");
        tally_and_finish;
    endtask
    task automatic tick(input integer k);
        repeat (k) @(posedge sys_clk);
    endtask
    // bready is raised only after bvalid shows, so the answer must stand
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
        integer n;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n = n + 1) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        if (n == 40) give_up;
        s_axi_bready <= 1'b0;
        if (er !== ANY) check("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
        integer n;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n = n + 1) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        if (n == 40) give_up;
        s_axi_rready <= 1'b0;
        check("rdata", {24'h000000, e}, s_axi_rdata);
        check("rresp", er, s_axi_rresp);
    endtask
    ////////////////////////////////////////////////
    initial begin
        {sys_clk, rst_n, overTempCmp, lowSupplyCmp, reducedPowerMode, shutdownMode, testModeEn} = 7'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        {badCount, testsRun} = 64'h0;
        tick(5);
        rst_n <= 1'b1;
        tick(2);
        rd(TEMP, 8'h10, OK);
        rd(SUP, 8'h00, OK);
        rd(IST, 8'h00, OK);
        for (i = 0; i < 5; i = i + 1) begin
            v = tbl[i];
            wr(TEMP, v, 4'h1, OK);
            rd(TEMP, v, OK);
            check("tempSenseEnable", v[3], tempSenseEnable);
            check("adcInternalRoute", v[4], adcInternalRoute);
            check("adcSelectBandgap", v[4] & v[5], adcSelectBandgap);
            check("adcSelectTemp", v[4] & ~v[5], adcSelectTemp);
        end
        wr(TEMP, 8'hC8, 4'h1, OK);
        check("tempTestBits", 2'b00, tempTestBits);
        testModeEn <= 1'b1;
        wr(TEMP, 8'hC8, 4'h1, OK);
        rd(TEMP, 8'h08, OK);
        check("tempTestBits", 2'b11, tempTestBits);
        wr(TEMP, 8'h0C, 4'h1, OK);
        testModeEn <= 1'b0;
        rd(TEMP, 8'h08, OK);
        wr(TEMP, 8'h0A, 4'h1, OK);
        overTempCmp <= 1'b1;
        tick(6);
        rd(TEMP, 8'h0F, OK);
        check("overTempIrq", 1'b1, overTempIrq);
        wr(TEMP, 8'h0A, 4'h1, OK);
        rd(TEMP, 8'h0F, OK);
        wr(TEMP, 8'h0B, 4'h1, OK);
        rd(TEMP, 8'h0E, OK);
        check("overTempIrq", 1'b0, overTempIrq);
        overTempCmp <= 1'b0;
        tick(6);
        rd(TEMP, 8'h0B, OK);
        wr(TEMP, 8'h0B, 4'h1, OK);
        tick(6);
        rd(TEMP, 8'h0A, OK);
        wr(TEMP, 8'h02, 4'h1, OK);
        overTempCmp <= 1'b1;
        tick(6);
        rd(TEMP, 8'h02, OK);
        overTempCmp <= 1'b0;
        wr(SUP, 8'h02, 4'h1, OK);
        lowSupplyCmp <= 1'b1;
        tick(6);
        rd(SUP, 8'h07, OK);
        check("lowSupplyIrq", 1'b1, lowSupplyIrq);
        wr(SUP, 8'h04, 4'h1, OK);
        rd(SUP, 8'h05, OK);
        check("lowSupplyIrq", 1'b0, lowSupplyIrq);
        wr(SUP, 8'h03, 4'h1, OK);
        rd(SUP, 8'h06, OK);
        for (m = 0; m < 2; m = m + 1) begin
            reducedPowerMode <= (m == 0);
            shutdownMode <= (m == 1);
            tick(6);
            check("monitorsActive", 1'b0, monitorsActive);
            rd(SUP, 8'h03, OK);
            reducedPowerMode <= 1'b0;
            shutdownMode <= 1'b0;
            tick(6);
            rd(SUP, 8'h07, OK);
            wr(SUP, 8'h03, 4'h1, OK);
        end
        rd(IST, 8'h03, OK);
        check("irqOut", 1'b0, irqOut);
        wr(IEN, 8'h02, 4'h1, OK);
        rd(IEN, 8'h02, OK);
        check("irqOut", 1'b1, irqOut);
        wr(ICLR, 8'h02, 4'h1, OK);
        rd(IST, 8'h01, OK);
        rd(ICLR, 8'h00, OK);
        check("irqOut", 1'b0, irqOut);
        wr(IEN, 8'h03, 4'h1, OK);
        check("irqOut", 1'b1, irqOut);
        wr(ICLR, 8'h01, 4'h1, OK);
        rd(IST, 8'h00, OK);
        check("irqOut", 1'b0, irqOut);
        wr(10'h2FB, 8'h01, 4'h1, ERR);
        rd(10'h000, 8'h00, ERR);
        rd(RSVD, 8'h00, OK);
        wr(RATEL, 8'h5A, 4'h1, OK);
        wr(RATEL, 8'h33, 4'h0, OK);
        wr(WAKE, 8'h04, 4'h1, OK);
        wr(RATEL, 8'hA5, 4'h1, OK);
        rd(RATEL, 8'h5A, OK);
        check("wakeControl", 8'h04, wakeControl);
        check("wakeRateValue", 16'h005A, wakeRateValue);
        wr(WTRIM, 8'hFF, 4'h1, OK);
        rd(WTRIM, 8'hFC, OK);
        wr(TTRIM, 8'hFF, 4'h1, OK);
        rd(TTRIM, 8'h8F, OK);
        check("tempTrimValue", 4'hF, tempTrimValue);
        check("tempTrimOutputEnable", 1'b1, tempTrimOutputEnable);
        tally_and_finish;
    end
endmodule // stm_monitor_bench
